/* File: core/rprp_defs.vh */
/*
 Constants of the packet report port: register offsets, field positions,
 reset values, report field lengths and timing counts.
 Assumes it is included by its bare name from the design files.
*/
`ifndef RPRP_DEFS_VH
`define RPRP_DEFS_VH

`define RPRP_OFF_SIZE       8'h00
`define RPRP_OFF_CTRL       8'h04
`define RPRP_OFF_LAST_LO    8'h08
`define RPRP_OFF_LAST_HI    8'h0c
`define RPRP_OFF_PREF_LO    8'h10
`define RPRP_OFF_PREF_HI    8'h14
`define RPRP_OFF_STATUS     8'h18
`define RPRP_OFF_LASTREP    8'h1c

`define RPRP_SIZE_RST       11'h7ff
`define RPRP_CTRL_RST       3'h0
`define RPRP_SA_RST         48'h000000000000

`define RPRP_CTRL_LAST_BIT  0
`define RPRP_CTRL_PREF_BIT  1
`define RPRP_CTRL_MCAST_BIT 2

`define RPRP_MIN_BODY       12'd14
`define RPRP_FULL_SIZE      11'd1536
`define RPRP_OVERSIZE       12'd1535
`define RPRP_DA_LAST        12'd5

`define RPRP_FLAG_BCAST     0
`define RPRP_FLAG_MCAST     1
`define RPRP_FLAG_OVERSIZE  3
`define RPRP_FLAG_BITRATE   4
`define RPRP_FLAG_FRAMING   5
`define RPRP_FLAG_CRC       6

`define RPRP_BYTE_LEN       6'd8
`define RPRP_STAT1_LEN      6'd8
`define RPRP_STAT2_LEN      6'd24
`define RPRP_FCS_LEN        6'd32

`define RPRP_CRC_INIT       32'hffffffff
`define RPRP_CRC_POLY       32'hedb88320

`define RPRP_REF_CLK_NS     50
`define RPRP_REPORT_CLK_NS  100
`define RPRP_HALF_CYC       ((`RPRP_REPORT_CLK_NS / 2) / `RPRP_REF_CLK_NS)

`endif

/* File: core/rprp_report_port.v */
/*
 Packet report port: copies each repeated packet that starts while the link is free, cut to a programmable
 length, out on a serial report link with two statistics fields and a new FCS.
 Assumes the repeater core delivers packet bytes on ref_clk, software uses APB,
 and an external buffer gated by report buffer drive joins the shared link.
*/
// Added by the designer: the placing of the registers and the APB register port.
`timescale 1ns/1ps
`include "rprp_defs.vh"

module rprp_report_port #(
   parameter BUF_AW = 4
) (
   input  wire        ref_clk,
   input  wire        rst_n,
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [7:0]  paddr,
   input  wire [31:0] pwdata,
   output reg  [31:0] prdata,
   output reg         pready,
   output reg         pslverr,
   input  wire        pktStart,
   input  wire        pktByteValid,
   input  wire [7:0]  pktByte,
   input  wire        pktEnd,
   input  wire [7:0]  pktPort,
   input  wire        pktBitRateErr,
   input  wire        pktFramingErr,
   input  wire        pktCrcErr,
   output reg         reportClk,
   output reg         reportSerialData,
   output reg         reportActiveOutN,
   input  wire        reportActiveInN,
   output reg         reportBufferDrive,
   output reg         reportTagFlag
);

   localparam BUF_DEPTH = 1 << BUF_AW;
   localparam [2:0] ST_IDLE  = 3'h0;
   localparam [2:0] ST_BODY  = 3'h1;
   localparam [2:0] ST_STAT1 = 3'h2;
   localparam [2:0] ST_STAT2 = 3'h3;
   localparam [2:0] ST_FCS   = 3'h4;
   localparam [7:0] HALF_CYC = (`RPRP_HALF_CYC < 1) ? 8'd1 : `RPRP_HALF_CYC;

   function [31:0] crcBit;
      input [31:0] crc;
      input        bitIn;
      begin
         crcBit = (crc >> 1) ^ (((crc[0] ^ bitIn) == 1'b1) ? `RPRP_CRC_POLY : 32'h00000000);
      end
   endfunction

   reg  [10:0]       sizeQ;
   reg  [2:0]        ctrlQ;
   reg  [47:0]       lastSaQ;
   reg  [47:0]       prefSaQ;
   reg  [7:0]        sentRepQ;
   reg  [7:0]        skipRepQ;
   reg  [7:0]        truncRepQ;
   reg  [31:0]       readData;
   reg               readErr;
   reg               actSyncA;
   reg               actSyncB;
   reg  [7:0]        divQ;
   reg  [2:0]        stQ;
   reg  [11:0]       rxCntQ;
   reg  [47:0]       daQ;
   reg               daDoneQ;
   reg               pktDoneQ;
   reg  [7:0]        flagsQ;
   reg  [7:0]        portQ;
   reg  [7:0]        bufMem [0:BUF_DEPTH-1];
   reg  [BUF_AW:0]   wrPtrQ;
   reg  [BUF_AW:0]   rdPtrQ;
   reg  [11:0]       sentCntQ;
   reg  [31:0]       shQ;
   reg  [5:0]        bitsQ;
   reg               presQ;
   reg               crcOnQ;
   reg  [31:0]       crcQ;
   reg               fAvail;
   reg  [31:0]       fData;
   reg  [5:0]        fLen;
   reg  [2:0]        fNext;
   reg               fPop;
   reg               fTag;
   reg               fCrc;
   reg               fTrunc;
   wire              tick;
   wire              apbAccess;
   wire              bufEmpty;
   wire              bufFull;
   wire              push;
   wire              accept;
   wire              isBcast;
   wire              isMcast;
   wire              daValid;
   wire              fullMode;
   wire [11:0]       limit;
   wire [BUF_AW:0]   bufCnt;

   assign apbAccess = psel & penable & pready;
   assign tick      = (divQ == (HALF_CYC - 8'd1));
   assign bufCnt    = wrPtrQ - rdPtrQ;
   assign bufEmpty  = (bufCnt == {(BUF_AW+1){1'b0}});
   assign bufFull   = bufCnt[BUF_AW];
   assign isBcast   = (daQ == 48'hffffffffffff);
   assign isMcast   = daQ[0] & ~isBcast;
   assign daValid   = (ctrlQ[`RPRP_CTRL_LAST_BIT] & (daQ == lastSaQ))
                    | (ctrlQ[`RPRP_CTRL_PREF_BIT] & (daQ == prefSaQ));
   assign fullMode  = isBcast | daValid
                    | (ctrlQ[`RPRP_CTRL_MCAST_BIT] & isMcast)
                    | (sizeQ >= `RPRP_FULL_SIZE);
   assign limit     = ({1'b0, sizeQ} <= `RPRP_MIN_BODY) ? `RPRP_MIN_BODY : {1'b0, sizeQ};
   assign accept    = pktStart & (stQ == ST_IDLE) & actSyncB;
   assign push      = pktByteValid & ~pktDoneQ & (stQ == ST_BODY) & ~bufFull;

   always @* begin
      readData = 32'h00000000;
      readErr  = 1'b0;
      case (paddr)
         `RPRP_OFF_SIZE:    readData = {21'h000000, sizeQ};
         `RPRP_OFF_CTRL:    readData = {29'h00000000, ctrlQ};
         `RPRP_OFF_LAST_LO: readData = lastSaQ[31:0];
         `RPRP_OFF_LAST_HI: readData = {16'h0000, lastSaQ[47:32]};
         `RPRP_OFF_PREF_LO: readData = prefSaQ[31:0];
         `RPRP_OFF_PREF_HI: readData = {16'h0000, prefSaQ[47:32]};
         `RPRP_OFF_STATUS:  readData = {truncRepQ, skipRepQ, sentRepQ, 4'h0, ~actSyncB, stQ};
         `RPRP_OFF_LASTREP: readData = {portQ, 4'h0, rxCntQ, flagsQ};
         default:           readErr  = 1'b1;
      endcase
   end

   // One wait state lets prdata and pready come straight from flip-flops.
   always @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h00000000;
         sizeQ   <= `RPRP_SIZE_RST;
         ctrlQ   <= `RPRP_CTRL_RST;
         lastSaQ <= `RPRP_SA_RST;
         prefSaQ <= `RPRP_SA_RST;
      end else begin
         if (psel && penable && !pready) begin
            pready  <= 1'b1;
            pslverr <= readErr;
            prdata  <= pwrite ? 32'h00000000 : readData;
         end else begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
         end
         if (apbAccess && pwrite && !pslverr) begin
            case (paddr)
               `RPRP_OFF_SIZE:    sizeQ            <= pwdata[10:0];
               `RPRP_OFF_CTRL:    ctrlQ            <= pwdata[2:0];
               `RPRP_OFF_LAST_LO: lastSaQ[31:0]    <= pwdata;
               `RPRP_OFF_LAST_HI: lastSaQ[47:32]   <= pwdata[15:0];
               `RPRP_OFF_PREF_LO: prefSaQ[31:0]    <= pwdata;
               `RPRP_OFF_PREF_HI: prefSaQ[47:32]   <= pwdata[15:0];
               default:           sizeQ            <= sizeQ;
            endcase
         end
      end
   end

   always @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         actSyncA <= 1'b1;
         actSyncB <= 1'b1;
      end else begin
         actSyncA <= reportActiveInN;
         actSyncB <= actSyncA;
      end
   end

   always @(posedge ref_clk) begin
      if (push) begin
         bufMem[wrPtrQ[BUF_AW-1:0]] <= pktByte;
      end
   end

   // Field selection: what the serialiser loads once the current field is out.
   always @* begin
      fAvail = 1'b0;
      fData  = 32'h00000000;
      fLen   = `RPRP_BYTE_LEN;
      fNext  = stQ;
      fPop   = 1'b0;
      fTag   = reportTagFlag;
      fCrc   = 1'b1;
      fTrunc = 1'b0;
      case (stQ)
         ST_BODY: begin
            if (daDoneQ && !bufEmpty && (fullMode || sentCntQ < limit)) begin
               fAvail = 1'b1;
               fData  = {24'h000000, bufMem[rdPtrQ[BUF_AW-1:0]]};
               fPop   = 1'b1;
            end else if (daDoneQ && ((!fullMode && sentCntQ >= limit) || (pktDoneQ && bufEmpty))) begin
               fAvail = 1'b1;
               fData  = {24'h000000, portQ};
               fLen   = `RPRP_STAT1_LEN;
               fNext  = ST_STAT1;
               fTag   = 1'b1;
               fTrunc = !fullMode && !(pktDoneQ && bufEmpty);
            end
         end
         ST_STAT1: begin
            if (pktDoneQ) begin
               fAvail = 1'b1;
               fData  = {8'h00, 4'h0, rxCntQ, flagsQ};
               fLen   = `RPRP_STAT2_LEN;
               fNext  = ST_STAT2;
               fTag   = 1'b1;
            end
         end
         ST_STAT2: begin
            fAvail = 1'b1;
            fData  = ~crcQ;
            fLen   = `RPRP_FCS_LEN;
            fNext  = ST_FCS;
            fTag   = 1'b0;
            fCrc   = 1'b0;
         end
         default: begin
            fAvail = 1'b0;
         end
      endcase
   end

   always @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         divQ              <= 8'h00;
         stQ               <= ST_IDLE;
         rxCntQ            <= 12'h000;
         daQ               <= 48'h000000000000;
         daDoneQ           <= 1'b0;
         pktDoneQ          <= 1'b0;
         flagsQ            <= 8'h00;
         portQ             <= 8'h00;
         wrPtrQ            <= {(BUF_AW+1){1'b0}};
         rdPtrQ            <= {(BUF_AW+1){1'b0}};
         sentCntQ          <= 12'h000;
         shQ               <= 32'h00000000;
         bitsQ             <= 6'h00;
         presQ             <= 1'b0;
         crcOnQ            <= 1'b0;
         crcQ              <= `RPRP_CRC_INIT;
         sentRepQ          <= 8'h00;
         skipRepQ          <= 8'h00;
         truncRepQ         <= 8'h00;
         reportClk         <= 1'b0;
         reportSerialData  <= 1'b0;
         reportActiveOutN  <= 1'b1;
         reportBufferDrive <= 1'b0;
         reportTagFlag     <= 1'b0;
      end else begin
         divQ <= tick ? 8'h00 : divQ + 8'd1;
         if (push) begin
            wrPtrQ <= wrPtrQ + {{BUF_AW{1'b0}}, 1'b1};
         end
         if (pktStart && !accept) begin
            skipRepQ <= skipRepQ + 8'd1;
         end
         if (accept) begin
            stQ               <= ST_BODY;
            rxCntQ            <= 12'h000;
            daDoneQ           <= 1'b0;
            pktDoneQ          <= 1'b0;
            portQ             <= pktPort;
            wrPtrQ            <= {(BUF_AW+1){1'b0}};
            rdPtrQ            <= {(BUF_AW+1){1'b0}};
            sentCntQ          <= 12'h000;
            bitsQ             <= 6'h00;
            presQ             <= 1'b0;
            crcQ              <= `RPRP_CRC_INIT;
            reportClk         <= 1'b0;
            reportActiveOutN  <= 1'b0;
            reportBufferDrive <= 1'b1;
         end else if (stQ != ST_IDLE) begin
            if (pktByteValid && !pktDoneQ) begin
               if (rxCntQ <= `RPRP_DA_LAST) begin
                  daQ[{rxCntQ[2:0], 3'b000} +: 8] <= pktByte;
               end
               if (rxCntQ == `RPRP_DA_LAST) begin
                  daDoneQ <= 1'b1;
               end
               if (rxCntQ != 12'hfff) begin
                  rxCntQ <= rxCntQ + 12'd1;
               end
            end
            if (pktEnd && !pktDoneQ) begin
               // A runt shorter than the address still gets a report.
               pktDoneQ <= 1'b1;
               daDoneQ  <= 1'b1;
               flagsQ   <= 8'h00;
               flagsQ[`RPRP_FLAG_BCAST]    <= isBcast & daDoneQ;
               flagsQ[`RPRP_FLAG_MCAST]    <= isMcast & daDoneQ;
               flagsQ[`RPRP_FLAG_OVERSIZE] <= (rxCntQ > `RPRP_OVERSIZE);
               flagsQ[`RPRP_FLAG_BITRATE]  <= pktBitRateErr;
               flagsQ[`RPRP_FLAG_FRAMING]  <= pktFramingErr;
               flagsQ[`RPRP_FLAG_CRC]      <= pktCrcErr;
            end
            // Data changes only while the clock is low, so it is settled at each rise.
            if (tick) begin
               if (!reportClk && presQ) begin
                  reportClk <= 1'b1;
                  presQ     <= 1'b0;
               end else begin
                  reportClk <= 1'b0;
                  if (bitsQ != 6'h00) begin
                     reportSerialData <= shQ[0];
                     shQ              <= shQ >> 1;
                     bitsQ            <= bitsQ - 6'd1;
                     presQ            <= 1'b1;
                     if (crcOnQ) begin
                        crcQ <= crcBit(crcQ, shQ[0]);
                     end
                  end else if (fAvail) begin
                     reportSerialData <= fData[0];
                     shQ              <= fData >> 1;
                     bitsQ            <= fLen - 6'd1;
                     presQ            <= 1'b1;
                     stQ              <= fNext;
                     reportTagFlag    <= fTag;
                     crcOnQ           <= fCrc;
                     if (fCrc) begin
                        crcQ <= crcBit(crcQ, fData[0]);
                     end
                     if (fPop) begin
                        rdPtrQ   <= rdPtrQ + {{BUF_AW{1'b0}}, 1'b1};
                        sentCntQ <= sentCntQ + 12'd1;
                     end
                     if (fTrunc) begin
                        truncRepQ <= truncRepQ + 8'd1;
                     end
                  end else if (stQ == ST_FCS) begin
                     stQ               <= ST_IDLE;
                     sentRepQ          <= sentRepQ + 8'd1;
                     reportSerialData  <= 1'b0;
                     reportTagFlag     <= 1'b0;
                     reportActiveOutN  <= 1'b1;
                     reportBufferDrive <= 1'b0;
                  end else begin
                     presQ <= 1'b0;
                  end
               end
            end
         end
      end
   end

endmodule // rprp_report_port

/* File: tb/rprp_mac_model.sv */
/* Receiving MAC model: collects report bits at report clock rises.
   Assumes the bench clears it before each packet. */
`timescale 1ns/1ps
module rprp_mac_model (
   input wire reportClk,
   input wire reportSerialData,
   input wire reportBufferDrive,
   input wire reportTagFlag
);
   logic bits [$];
   int   tagBits;
   // The shared link is only listened to while this device drives it.
   always @(posedge reportClk) begin
      if (reportBufferDrive) begin
         bits.push_back(reportSerialData);
         if (reportTagFlag) tagBits++;
      end
   end
   task clear();
      bits.delete();
      tagBits = 0;
   endtask
endmodule // rprp_mac_model

/* File: tb/rprp_report_port_sva.sv */
/* Checker of the report link pins and the APB handshake.
   Assumes it is bound to rprp_report_port and sees only its ports. */
`timescale 1ns/1ps
module rprp_report_port_sva (
   input wire ref_clk,
   input wire rst_n,
   input wire psel,
   input wire penable,
   input wire pready,
   input wire pslverr,
   input wire pktStart,
   input wire reportClk,
   input wire reportSerialData,
   input wire reportActiveOutN,
   input wire reportActiveInN,
   input wire reportBufferDrive,
   input wire reportTagFlag
);
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!rst_n);
   chk_clk_pulse: assert property (reportClk |=> !reportClk)
      else $error("report clock high too long");
   chk_data_hold: assert property (reportClk |-> $stable(reportSerialData))
      else $error("serial data moved at clock rise");
   chk_idle_clk: assert property (!reportBufferDrive |-> !reportClk)
      else $error("report clock runs without drive");
   chk_drive_span: assert property (reportBufferDrive != reportActiveOutN)
      else $error("drive and active disagree");
   chk_tag_inside: assert property (reportTagFlag |-> reportBufferDrive)
      else $error("tag flag outside a report");
   chk_fcs_follows: assert property ($fell(reportTagFlag) |-> !reportActiveOutN)
      else $error("report ended with the tag");
   // Three samples at one level let the two-flop synchroniser see the shared input.
   chk_start_taken: assert property ((reportActiveOutN && reportActiveInN) [*3] ##0 pktStart |=> !reportActiveOutN)
      else $error("idle start not taken");
   chk_start_refused: assert property ((!reportActiveInN && reportActiveOutN) [*3] ##0 pktStart |=> reportActiveOutN)
      else $error("start taken while other device active");
   chk_apb_wait: assert property (psel && $rose(penable) |=> pready)
      else $error("apb answer late");
   chk_ready_pulse: assert property (pready |=> !pready)
      else $error("pready held");
   chk_err_ready: assert property (pslverr |-> pready)
      else $error("pslverr without pready");
   cover property (pktStart ##1 !reportActiveOutN);
   cover property ($rose(reportTagFlag));
   cover property (pready && pslverr);
endmodule // rprp_report_port_sva

bind rprp_report_port rprp_report_port_sva chk (
   .ref_clk          (ref_clk),
   .rst_n            (rst_n),
   .psel             (psel),
   .penable          (penable),
   .pready           (pready),
   .pslverr          (pslverr),
   .pktStart         (pktStart),
   .reportClk        (reportClk),
   .reportSerialData (reportSerialData),
   .reportActiveOutN (reportActiveOutN),
   .reportActiveInN  (reportActiveInN),
   .reportBufferDrive(reportBufferDrive),
   .reportTagFlag    (reportTagFlag)
);

/* File: tb/rprp_report_port_tb.sv */
/* Self-checking bench of the packet report port with a MAC model.
   Assumes the packet source feeds one byte per 16 clock cycles. */
`timescale 1ns/1ps
`include "rprp_defs.vh"
module rprp_report_port_tb;
   typedef struct packed {
      logic [10:0] size; logic [2:0] ctrl; logic [2:0] da; logic [11:0] len;
      logic [2:0]  err;  logic [11:0] body; logic [7:0] flags;
   } rprp_row_t;
   logic        ref_clk, rst_n, psel, penable, pwrite, pready, pslverr;
   logic [7:0]  paddr, pktByte, pktPort;
   logic [31:0] pwdata, prdata, crc;
   logic        pktStart, pktByteValid, pktEnd, pktBitRateErr, pktFramingErr, pktCrcErr;
   logic        reportClk, reportSerialData, reportActiveOutN, reportActiveInN, reportBufferDrive, reportTagFlag;
   logic        tagAtEnd;
   int          errTotal = 0, nTests = 0, cyc = 0, pos, nAtEnd;
   logic [47:0] daTab [5] = '{48'h010000000002, 48'hffffffffffff, 48'h010000000003,
                              48'h554433221102, 48'heeddccbbaa02};
   rprp_row_t   rows [12] = '{
      {11'h00e, 3'h0, 3'h0, 12'h028, 3'h0, 12'h00e, 8'h00},
      {11'h00a, 3'h0, 3'h0, 12'h01e, 3'h0, 12'h00e, 8'h00},
      {11'h014, 3'h0, 3'h0, 12'h014, 3'h0, 12'h014, 8'h00},
      {11'h014, 3'h0, 3'h0, 12'h015, 3'h7, 12'h014, 8'h70},
      {11'h00e, 3'h0, 3'h1, 12'h01e, 3'h0, 12'h01e, 8'h01},
      {11'h00e, 3'h0, 3'h2, 12'h01e, 3'h0, 12'h00e, 8'h02},
      {11'h00e, 3'h4, 3'h2, 12'h01e, 3'h0, 12'h01e, 8'h02},
      {11'h00e, 3'h0, 3'h3, 12'h01e, 3'h0, 12'h00e, 8'h00},
      {11'h00e, 3'h1, 3'h3, 12'h01e, 3'h0, 12'h01e, 8'h00},
      {11'h00e, 3'h1, 3'h4, 12'h01e, 3'h0, 12'h00e, 8'h00},
      {11'h00e, 3'h2, 3'h4, 12'h01e, 3'h0, 12'h01e, 8'h00},
      {11'h7ff, 3'h0, 3'h0, 12'h028, 3'h0, 12'h028, 8'h00}};

   rprp_report_port #(.BUF_AW(4)) dut (.ref_clk(ref_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .pktStart(pktStart), .pktByteValid(pktByteValid), .pktByte(pktByte), .pktEnd(pktEnd), .pktPort(pktPort),
      .pktBitRateErr(pktBitRateErr), .pktFramingErr(pktFramingErr), .pktCrcErr(pktCrcErr),
      .reportClk(reportClk), .reportSerialData(reportSerialData), .reportActiveOutN(reportActiveOutN),
      .reportActiveInN(reportActiveInN), .reportBufferDrive(reportBufferDrive), .reportTagFlag(reportTagFlag));
   rprp_mac_model mac (.reportClk(reportClk), .reportSerialData(reportSerialData),
      .reportBufferDrive(reportBufferDrive), .reportTagFlag(reportTagFlag));

   initial begin
      ref_clk = 1'b0;
      forever #25 ref_clk = ~ref_clk;
   end
   // The ceiling leaves about seven times the time that the packets should need.
   always @(posedge ref_clk) begin
      cyc <= cyc + 1;
      if (cyc == 60000) begin
         errTotal++;
         $display("[FAIL] %0t timeout", $time);
         testDone();
      end
   end

   task testDone();
      $display("comparisons %0d mismatches %0d", nTests, errTotal);
      if (errTotal == 0 && nTests > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      nTests++;
      if (got !== exp) begin
         errTotal++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] rd,
                      output logic er);
      @(posedge ref_clk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge ref_clk);
      penable <= 1'b1;
      do @(posedge ref_clk); while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic apbW(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      logic        e;
      apb(1'b1, a, d, r, e);
   endtask
   task automatic rdChk(input logic [7:0] a, input logic [31:0] exp, input logic expErr);
      logic [31:0] d;
      logic        e;
      apb(1'b0, a, 32'h0, d, e);
      cmp(d, exp);
      cmp({31'h0, e}, {31'h0, expErr});
   endtask
   function automatic logic [7:0] pb(input logic [47:0] da, input int i);
      pb = (i < 6) ? da[8 * i +: 8] : i[7:0];
   endfunction
   task automatic sendPkt(input logic [47:0] da, input logic [11:0] len, input logic [7:0] port,
                          input logic [2:0] err);
      @(posedge ref_clk);
      pktStart <= 1'b1;
      pktPort <= port;
      @(posedge ref_clk);
      pktStart <= 1'b0;
      for (int i = 0; i < len; i++) begin
         repeat (15) @(posedge ref_clk);
         pktByteValid <= 1'b1;
         pktByte <= pb(da, i);
         @(posedge ref_clk);
         pktByteValid <= 1'b0;
      end
      repeat (4) @(posedge ref_clk);
      nAtEnd = mac.bits.size();
      tagAtEnd = reportTagFlag;
      pktEnd <= 1'b1;
      {pktCrcErr, pktFramingErr, pktBitRateErr} <= err;
      @(posedge ref_clk);
      pktEnd <= 1'b0;
      for (int i = 0; i < 4000 && reportActiveOutN !== 1'b1; i++) @(posedge ref_clk);
   endtask
   task automatic fieldChk(input logic [31:0] v, input int n);
      logic [31:0] g;
      g = 32'h0;
      for (int i = 0; i < n; i++) begin
         g[i] = mac.bits[pos + i];
         crc = (crc >> 1) ^ ((crc[0] ^ v[i]) ? `RPRP_CRC_POLY : 32'h0);
      end
      cmp(g, v);
      pos += n;
   endtask
   task automatic runRow(input rprp_row_t r);
      logic [31:0] f;
      apbW(`RPRP_OFF_SIZE, {21'h0, r.size});
      apbW(`RPRP_OFF_CTRL, {29'h0, r.ctrl});
      mac.clear();
      sendPkt(daTab[r.da], r.len, r.len[7:0] ^ 8'h5a, r.err);
      cmp(mac.bits.size(), r.body * 8 + 64);
      cmp(mac.tagBits, 32);
      // Only a packet that outlasts the cut body and first field makes the clock halt.
      if (r.len > r.body + 8) begin
         cmp(nAtEnd, r.body * 8 + 8);
         cmp({31'h0, tagAtEnd}, 32'h1);
      end else begin
         cmp({31'h0, tagAtEnd}, 32'h0);
      end
      pos = 0;
      crc = `RPRP_CRC_INIT;
      for (int i = 0; i < r.body; i++) fieldChk({24'h0, pb(daTab[r.da], i)}, 8);
      fieldChk({24'h0, r.len[7:0] ^ 8'h5a}, 8);
      fieldChk({12'h0, r.len, r.flags}, 24);
      f = ~crc;
      fieldChk(f, 32);
   endtask

   initial begin
      {rst_n, psel, penable, pwrite, paddr, pwdata} = '0;
      {pktStart, pktByteValid, pktByte, pktEnd, pktPort, pktBitRateErr, pktFramingErr, pktCrcErr} = '0;
      reportActiveInN = 1'b1;
      repeat (6) @(posedge ref_clk);
      rst_n <= 1'b1;
      apbW(`RPRP_OFF_LAST_LO, 32'h33221102);
      apbW(`RPRP_OFF_LAST_HI, 32'h00005544);
      apbW(`RPRP_OFF_PREF_LO, 32'hccbbaa02);
      apbW(`RPRP_OFF_PREF_HI, 32'h0000eedd);
      foreach (rows[k]) runRow(rows[k]);
      @(posedge ref_clk);
      reportActiveInN <= 1'b0;
      apbW(`RPRP_OFF_SIZE, 32'h0000000e);
      mac.clear();
      sendPkt(daTab[0], 12'h014, 8'h05, 3'h0);
      cmp(mac.bits.size(), 0);
      rdChk(`RPRP_OFF_STATUS, 32'h06010c08, 1'b0);
      rdChk(`RPRP_OFF_LASTREP, 32'h72002800, 1'b0);
      reportActiveInN <= 1'b1;
      rst_n <= 1'b0;
      repeat (6) @(posedge ref_clk);
      rst_n <= 1'b1;
      rdChk(`RPRP_OFF_SIZE, 32'h000007ff, 1'b0);
      rdChk(`RPRP_OFF_CTRL, 32'h0, 1'b0);
      rdChk(`RPRP_OFF_LAST_LO, 32'h0, 1'b0);
      rdChk(`RPRP_OFF_PREF_HI, 32'h0, 1'b0);
      rdChk(8'h20, 32'h0, 1'b1);
      testDone();
   end
endmodule // rprp_report_port_tb
